// [common/servo_timer_pkg.sv]
// shared constants and carrier types for the servo timer group
package servo_timer_pkg;
	// clock and timing
	localparam int CLK_HZ         = 25_000_000; // system clock rate
	localparam int FREE_TICK_NS   = 125;        // free-running resolution
	localparam int TICK_A_NS      = 1000;       // frame/duty/timer a tick
	localparam int TICK_B_NS      = 2000;       // timer b and c tick
	localparam int PWM_CARRIER_HZ = 62_500;     // pwm carrier frequency
	// cycle counts, rounded down, never below one
	localparam int FREE_TICK_CYC =
		(CLK_HZ / 1000 * FREE_TICK_NS / 1_000_000 < 1)
		? 1 : CLK_HZ / 1000 * FREE_TICK_NS / 1_000_000;
	localparam int TICK_A_CYC = (CLK_HZ / 1000 * TICK_A_NS / 1_000_000 < 1)
		? 1 : CLK_HZ / 1000 * TICK_A_NS / 1_000_000;
	localparam int TICK_B_CYC = (CLK_HZ / 1000 * TICK_B_NS / 1_000_000 < 1)
		? 1 : CLK_HZ / 1000 * TICK_B_NS / 1_000_000;
	localparam int PWM_CARRIER_CYC = CLK_HZ / PWM_CARRIER_HZ;
	// widths
	localparam int FREE_W    = 22; // free-running counter
	localparam int TMR_W     = 16; // every 16-bit timer
	localparam int DIV_W     = 8;  // event divider
	localparam int TAPE_W    = 5;  // tape up/down counter
	localparam int PWM_HI_W  = 16; // fine pwm duty
	localparam int PWM_LO_W  = 8;  // coarse pwm duty
	localparam int CARRIER_W = 9;  // carrier phase counter
	localparam int PRE_W     = 6;  // prescaler counters
	localparam int NUM_CAP   = 6;  // free-running capture channels
	localparam int NUM_PWM   = 3;  // channels per pwm resolution
	// reset and limit values
	localparam logic [FREE_W-1:0]    FREE_RST = 22'h00_0000;
	localparam logic [TMR_W-1:0]     TMR_RST  = 16'h0000;
	localparam logic [TMR_W-1:0]     TMR_MAX  = 16'hffff;
	localparam logic [DIV_W-1:0]     DIV_RST  = 8'h00;
	localparam logic [TAPE_W-1:0]    TAPE_RST = 5'h00;
	localparam logic [TAPE_W-1:0]    TAPE_MAX = 5'h1f;
	localparam logic [PRE_W-1:0]     PRE_RST = 6'h00;
	localparam logic [CARRIER_W-1:0] CAR_RST = 9'h000;

	// sensor and control inputs, all synchronous levels
	typedef struct packed {
		logic ref_phase;               // reference phase
		logic drum_phase;              // drum phase sensor
		logic drum_speed;              // drum speed sensor
		logic capstan_speed;           // capstan speed sensor
		logic reel_take;               // take-up reel sensor
		logic reel_supply;             // supply reel sensor
		logic playback_control_signal; // tape control pulse
		logic external_irq_input_2;    // remote-control input
	} servo_in_t;

	// compare values held by the cpu side
	typedef struct packed {
		logic [TMR_W-1:0] frame_ref_compare;
		logic [TMR_W-1:0] frame_record_compare;
		logic [TMR_W-1:0] vsync_mask_compare;
		logic [TMR_W-1:0] duty_compare_a;
		logic [TMR_W-1:0] duty_compare_b;
		logic [DIV_W-1:0] event_divider_compare;
		logic [TMR_W-1:0] general_timer_a_compare;
		logic [TMR_W-1:0] general_timer_c_compare;
		logic [TAPE_W-1:0] tape_counter_compare;
	} compare_t;

	// one-cycle event pulses
	typedef struct packed {
		logic frame_ref_match;
		logic record_control_output;
		logic vsync_unmask;
		logic rtp_trigger;
		logic duty_match_a;
		logic duty_match_b;
		logic event_divider_out;
		logic timer_a_irq;
		logic timer_c_irq;
		logic tape_counter_irq;
	} event_t;

	// captured and counted values
	typedef struct packed {
		logic [FREE_W-1:0]              free_running_counter;
		logic [NUM_CAP-1:0][FREE_W-1:0] speed_phase_capture;
		logic [TMR_W-1:0]               frame_timer;
		logic [TMR_W-1:0]               capstan_phase_capture;
		logic [TMR_W-1:0]               control_period_capture;
		logic [TMR_W-1:0]               control_duty_timer;
		logic [DIV_W-1:0]               event_divider_counter;
		logic [TMR_W-1:0]              general_timer_a;
		logic [TMR_W-1:0]              general_timer_b;
		logic [TMR_W-1:0]              timer_b_capcompare;
		logic [TMR_W-1:0]              timer_b_capture;
		logic [TMR_W-1:0]              general_timer_c;
		logic [TAPE_W-1:0]              tape_updown_counter;
	} count_t;

	// pwm duty settings
	typedef struct packed {
		logic [NUM_PWM-1:0][PWM_HI_W-1:0] duty_hi;
		logic [NUM_PWM-1:0][PWM_LO_W-1:0] duty_lo;
	} pwm_duty_t;
endpackage

// [hdl/pwm_channel.sv]
// one pwm output compared against the shared carrier phase
`timescale 1ns/1ps
module pwm_channel #(
	parameter int W = 16 // duty resolution
) (
	input  wire logic                                  sys_clk,  // clock
	input  wire logic                                  rst_b,    // reset
	input  wire logic [servo_timer_pkg::CARRIER_W-1:0] carrier,  // phase
	input  wire logic [W-1:0]                          duty,     // duty
	output logic                                       pwm_out   // output
);
	import servo_timer_pkg::*;

	typedef struct packed {
		logic level; // registered output level
	} pwm_st_t;

	pwm_st_t                 st;       // state
	pwm_st_t                 next_st;  // next state
	logic [W+CARRIER_W-1:0]  ramp;     // phase scaled to duty range
	logic [W+CARRIER_W-1:0]  thresh;   // duty scaled to carrier length

	// scaling keeps the full duty range over a non-power-of-two period
	always_comb begin
		ramp    = {carrier, {W{1'b0}}};
		thresh  = (W+CARRIER_W)'(duty) * (W+CARRIER_W)'(PWM_CARRIER_CYC);
		next_st = st;
		next_st.level = ramp < thresh;
	end

	// output flop
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pwm_out = st.level;
endmodule

// [hdl/vcr_servo_timer_group.sv]
// servo timer group: capture counter, reference timers, pwm unit
`timescale 1ns/1ps
module vcr_servo_timer_group (
	input  wire logic                            sys_clk, // clock
	input  wire logic                            rst_b,   // async reset
	input  servo_timer_pkg::servo_in_t           sense,   // sensors
	input  servo_timer_pkg::compare_t            cfg,     // compares
	input  servo_timer_pkg::pwm_duty_t           duty,    // pwm duties
	output servo_timer_pkg::count_t              counts,  // counts, captures
	output servo_timer_pkg::event_t              events,  // pulses
	output logic [2*servo_timer_pkg::NUM_PWM-1:0] pwm      // pwm pins
);
	import servo_timer_pkg::*;

	typedef struct packed {
		logic [PRE_W-1:0]     pre_free; // free-running prescaler
		logic [PRE_W-1:0]     pre_a;   // 1 us prescaler
		logic [PRE_W-1:0]     pre_b;   // 2 us prescaler
		logic [CARRIER_W-1:0] carrier; // pwm carrier phase
		servo_in_t            last;    // previous input sample
		count_t               cnt;     // visible counts
		event_t               ev;      // visible pulses
	} st_t;

	st_t  st;      // state
	st_t  next_st; // next state
	logic tick_f;  // free-running tick
	logic tick_a;  // 1 us tick
	logic tick_b;  // 2 us tick
	logic pb_rise; // tape control rising edge
	logic pb_fall; // tape control falling edge
	logic rc_edge; // remote input edge, either way

	// rising edge against the previous sample
	function automatic logic rise(input logic last, input logic now);
		return now && !last;
	endfunction

	// wrapping step of a prescaler with terminal count
	function automatic logic [PRE_W-1:0] pre_step(input logic [PRE_W-1:0] p,
			input logic term);
		return term ? PRE_RST : PRE_W'(p + 1'b1);
	endfunction

	assign tick_f  = st.pre_free == PRE_W'(FREE_TICK_CYC - 1);
	assign tick_a  = st.pre_a == PRE_W'(TICK_A_CYC - 1);
	assign tick_b  = st.pre_b == PRE_W'(TICK_B_CYC - 1);
	assign pb_rise = rise(st.last.playback_control_signal,
		sense.playback_control_signal);
	assign pb_fall = rise(sense.playback_control_signal,
		st.last.playback_control_signal);
	assign rc_edge = st.last.external_irq_input_2 != sense.external_irq_input_2;

	// all counting, capture and event logic
	always_comb begin
		next_st      = st;
		next_st.ev   = '0; // pulses last one cycle
		next_st.last = sense;
		next_st.pre_free = pre_step(st.pre_free, tick_f);
		next_st.pre_a   = pre_step(st.pre_a, tick_a);
		next_st.pre_b   = pre_step(st.pre_b, tick_b);
		// carrier shared by all six outputs
		if (st.carrier == CARRIER_W'(PWM_CARRIER_CYC - 1)) begin
			next_st.carrier = CAR_RST;
		end else begin
			next_st.carrier = CARRIER_W'(st.carrier + 1'b1);
		end
		// free-running count wraps at 22 bits
		if (tick_f) begin
			next_st.cnt.free_running_counter =
				FREE_W'(st.cnt.free_running_counter + 1'b1);
		end
		// captures: ref phase, drum phase, drum speed, capstan, two reels
		if (rise(st.last.ref_phase, sense.ref_phase)) begin
			next_st.cnt.speed_phase_capture[0] = st.cnt.free_running_counter;
		end
		if (rise(st.last.drum_phase, sense.drum_phase)) begin
			next_st.cnt.speed_phase_capture[1] = st.cnt.free_running_counter;
		end
		if (rise(st.last.drum_speed, sense.drum_speed)) begin
			next_st.cnt.speed_phase_capture[2] = st.cnt.free_running_counter;
		end
		if (rise(st.last.capstan_speed, sense.capstan_speed)) begin
			next_st.cnt.speed_phase_capture[3] = st.cnt.free_running_counter;
		end
		if (rise(st.last.reel_take, sense.reel_take)) begin
			next_st.cnt.speed_phase_capture[4] = st.cnt.free_running_counter;
		end
		if (rise(st.last.reel_supply, sense.reel_supply)) begin
			next_st.cnt.speed_phase_capture[5] = st.cnt.free_running_counter;
		end
		// frame timer and its three compares
		if (tick_a) begin
			next_st.cnt.frame_timer = TMR_W'(st.cnt.frame_timer + 1'b1);
			next_st.ev.frame_ref_match =
				st.cnt.frame_timer == cfg.frame_ref_compare;
			next_st.ev.record_control_output =
				st.cnt.frame_timer == cfg.frame_record_compare;
			next_st.ev.vsync_unmask =
				st.cnt.frame_timer == cfg.vsync_mask_compare;
			next_st.ev.rtp_trigger =
				st.cnt.frame_timer == cfg.vsync_mask_compare;
		end
		// capstan phase: frame position at each tape control pulse
		if (pb_rise) begin
			next_st.cnt.capstan_phase_capture = st.cnt.frame_timer;
		end
		// duty timer restarts on each control pulse, keeping its period
		if (pb_rise) begin
			next_st.cnt.control_period_capture = st.cnt.control_duty_timer;
			next_st.cnt.control_duty_timer = TMR_RST;
		end else if (tick_a) begin
			next_st.cnt.control_duty_timer =
				TMR_W'(st.cnt.control_duty_timer + 1'b1);
			next_st.ev.duty_match_a = st.cnt.control_duty_timer == cfg.duty_compare_a;
			next_st.ev.duty_match_b = st.cnt.control_duty_timer == cfg.duty_compare_b;
		end
		// event divider on capstan sensor rising edges
		if (rise(st.last.capstan_speed, sense.capstan_speed)) begin
			if (st.cnt.event_divider_counter == cfg.event_divider_compare) begin
				next_st.cnt.event_divider_counter = DIV_RST;
				next_st.ev.event_divider_out = 1'b1;
			end else begin
				next_st.cnt.event_divider_counter =
					DIV_W'(st.cnt.event_divider_counter + 1'b1);
			end
		end
		// timer a: interval timer cleared by its compare
		if (tick_a) begin
			if (st.cnt.general_timer_a == cfg.general_timer_a_compare) begin
				next_st.cnt.general_timer_a = TMR_RST;
				next_st.ev.timer_a_irq = 1'b1;
			end else begin
				next_st.cnt.general_timer_a = TMR_W'(st.cnt.general_timer_a + 1'b1);
			end
		end
		// timer b: free 2 us count, captured on remote edges
		if (tick_b) begin
			next_st.cnt.general_timer_b =
				TMR_W'(st.cnt.general_timer_b + 1'b1);
		end
		if (rc_edge) begin
			next_st.cnt.timer_b_capcompare = st.cnt.general_timer_b;
			next_st.cnt.timer_b_capture = st.cnt.general_timer_b;
		end
		// timer c: interval timer cleared by its compare
		if (tick_b) begin
			if (st.cnt.general_timer_c == cfg.general_timer_c_compare) begin
				next_st.cnt.general_timer_c = TMR_RST;
				next_st.ev.timer_c_irq = 1'b1;
			end else begin
				next_st.cnt.general_timer_c = TMR_W'(st.cnt.general_timer_c + 1'b1);
			end
		end
		// tape counter; both edges can never come in one cycle
		if (pb_rise) begin
			next_st.cnt.tape_updown_counter =
				TAPE_W'(st.cnt.tape_updown_counter + 1'b1);
		end else if (pb_fall) begin
			if (st.cnt.tape_updown_counter == TAPE_RST) begin
				next_st.cnt.tape_updown_counter = TAPE_MAX;
				next_st.ev.tape_counter_irq = 1'b1;
			end else begin
				next_st.cnt.tape_updown_counter =
					TAPE_W'(st.cnt.tape_updown_counter - 1'b1);
			end
		end
		// match interrupt follows the new counter value
		if ((pb_rise || pb_fall) &&
				next_st.cnt.tape_updown_counter == cfg.tape_counter_compare) begin
			next_st.ev.tape_counter_irq = 1'b1;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign counts = st.cnt;
	assign events = st.ev;

	// fine channels 0..2 (drum, capstan, spare), coarse channels 3..5
	for (genvar i = 0; i < NUM_PWM; i++) begin : g_pwm
		pwm_channel #(.W(PWM_HI_W)) u_hi (
			.sys_clk (sys_clk),
			.rst_b   (rst_b),
			.carrier (st.carrier),
			.duty    (duty.duty_hi[i]),
			.pwm_out (pwm[i])
		);
		pwm_channel #(.W(PWM_LO_W)) u_lo (
			.sys_clk (sys_clk),
			.rst_b   (rst_b),
			.carrier (st.carrier),
			.duty    (duty.duty_lo[i]),
			.pwm_out (pwm[NUM_PWM+i])
		);
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_timer_a_clear: assert property (
		tick_a && st.cnt.general_timer_a == cfg.general_timer_a_compare
		|=> st.cnt.general_timer_a == TMR_RST && st.ev.timer_a_irq)
		else $error("timer a not cleared with interrupt");
	a_timer_c_clear: assert property (
		tick_b && st.cnt.general_timer_c == cfg.general_timer_c_compare
		|=> st.cnt.general_timer_c == TMR_RST && st.ev.timer_c_irq)
		else $error("timer c not cleared with interrupt");
	a_remote_capture: assert property (
		rc_edge |=> st.cnt.timer_b_capcompare == $past(st.cnt.general_timer_b)
		&& st.cnt.timer_b_capture == $past(st.cnt.general_timer_b))
		else $error("timer b capture lost");
	a_tape_count_up: assert property (
		pb_rise |=> st.cnt.tape_updown_counter ==
		TAPE_W'($past(st.cnt.tape_updown_counter) + 1'b1))
		else $error("tape counter did not count up");
	a_tape_underflow: assert property (
		pb_fall && st.cnt.tape_updown_counter == TAPE_RST
		|=> st.cnt.tape_updown_counter == TAPE_MAX && st.ev.tape_counter_irq)
		else $error("tape underflow not handled");
	a_vsync_unmask: assert property (
		st.ev.vsync_unmask |-> st.ev.rtp_trigger &&
		$past(st.cnt.frame_timer) == $past(cfg.vsync_mask_compare))
		else $error("vsync unmask without match");
	a_free_capture: assert property (
		rise(st.last.ref_phase, sense.ref_phase) |=>
		st.cnt.speed_phase_capture[0] == $past(st.cnt.free_running_counter))
		else $error("reference phase capture lost");
	a_timer_b_rate: assert property (
		$changed(st.cnt.general_timer_b) |->
		$past(st.pre_b) == PRE_W'(TICK_B_CYC - 1))
		else $error("timer b stepped off its tick");
	a_timer_b_wrap: assert property (
		tick_b && st.cnt.general_timer_b == TMR_MAX
		|=> st.cnt.general_timer_b == TMR_RST)
		else $error("timer b did not wrap");
	a_carrier_wrap: assert property (
		st.carrier == CARRIER_W'(PWM_CARRIER_CYC - 1) |=> st.carrier == CAR_RST)
		else $error("carrier period wrong");
endmodule

// [verification/servo_sensor_model.sv]
// sensor side model: tach, reel, tape control and remote pulse lines
`timescale 1ns/1ps
module servo_sensor_model (
	input  wire logic                  sys_clk, // clock
	output servo_timer_pkg::servo_in_t sense    // sensor levels
);
	import servo_timer_pkg::*;
	servo_in_t lvl; // levels the motors and tape present

	assign sense = lvl;

	// all lines start low, like idle tach outputs
	initial begin
		lvl = '0;
	end

	// toggle one line gap cycles after the last toggle, off the
	// sampling edge; then idle three cycles so captures can settle
	task automatic flip(input int idx, input int gap);
		repeat (gap - 3) @(negedge sys_clk);
		lvl[idx] = ~lvl[idx];
		repeat (3) @(negedge sys_clk);
	endtask
endmodule

// [verification/tb_vcr_servo_timer_group.sv]
// self-checking bench for the servo timer group
`timescale 1ns/1ps
module tb_vcr_servo_timer_group;
	import servo_timer_pkg::*;
	localparam logic [15:0] CMP_A = 16'h0005; // timer a period - 1
	localparam logic [15:0] CMP_C = 16'h0002; // timer c period - 1
	logic                 sys_clk;    // clock
	logic                 rst_b;      // reset
	servo_in_t            sense;      // from sensor model
	compare_t             cfg;        // compare values
	pwm_duty_t            duty;       // pwm duties
	count_t               counts;     // counts, captures
	event_t               events;     // pulses
	logic [2*NUM_PWM-1:0] pwm;        // pwm pins
	logic [5:0]           exp_q[$];   // expected {irq, tape count}
	logic [4:0]           prev_tape;  // last seen tape count
	int                   n_mismatch; // mismatches
	int                   compares;   // comparisons
	int                   cyc, last_a, last_c, vs_cnt, ev_cnt;
	int                   fr_cnt, dm_cnt; // frame and duty pulses

	vcr_servo_timer_group dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
		.sense(sense), .cfg(cfg), .duty(duty), .counts(counts),
		.events(events), .pwm(pwm));
	servo_sensor_model sm_u (.sys_clk(sys_clk), .sense(sense));

	// free-running clock, 40 ns period
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("n_mismatch=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// watcher: settled outputs at the falling edge
	always @(negedge sys_clk) begin
		if (rst_b) begin
			cyc++;
			// every tape count change or irq consumes one note
			if (events.tape_counter_irq
				|| counts.tape_updown_counter !== prev_tape) begin
				if (exp_q.size() > 0)
					check({events.tape_counter_irq, counts.tape_updown_counter},
						exp_q.pop_front());
				else check(0, 1);
			end
			prev_tape = counts.tape_updown_counter;
			if (events.timer_a_irq) begin
				check(counts.general_timer_a, 0);
				if (last_a > 0) check(cyc - last_a, (CMP_A + 1) * TICK_A_CYC);
				last_a = cyc;
			end
			if (events.timer_c_irq) begin
				check(counts.general_timer_c, 0);
				if (last_c > 0) check(cyc - last_c, (CMP_C + 1) * TICK_B_CYC);
				last_c = cyc;
			end
			// unmask and port trigger come together, timer one step past
			if (events.vsync_unmask || events.rtp_trigger) begin
				check({events.vsync_unmask, events.rtp_trigger}, 2'h3);
				check(counts.frame_timer, cfg.vsync_mask_compare + 1'b1);
			end
			// match pulses show up with the timer already stepped on
			if (events.frame_ref_match)
				check(counts.frame_timer, cfg.frame_ref_compare + 1'b1);
			if (events.record_control_output)
				check(counts.frame_timer, cfg.frame_record_compare + 1'b1);
			if (events.duty_match_a)
				check(counts.control_duty_timer, cfg.duty_compare_a + 1'b1);
			vs_cnt += events.vsync_unmask;
			ev_cnt += events.event_divider_out;
			fr_cnt += events.frame_ref_match + events.record_control_output;
			dm_cnt += events.duty_match_a;
		end
	end

	// tape edges: level alternates, so the count follows it
	task automatic tape_test(input logic [4:0] cmp);
		logic [15:0] f0;
		logic [4:0]  v;
		int          r, acc;
		cfg.tape_counter_compare = cmp;
		acc = 0;
		for (int k = 0; k < 6; k++) begin
			r = 1 + $urandom % 3;
			v = sense.playback_control_signal ? 5'h00 : 5'h01;
			exp_q.push_back({v == cmp, v});
			sm_u.flip(1, 25 * r);
			acc += r;
			if (v == 5'h01) begin
				// rises latch the frame timer, spacing in whole ticks
				if (k > 1) check(16'(counts.capstan_phase_capture - f0), acc);
				f0 = counts.capstan_phase_capture;
				acc = 0;
			end
		end
	endtask

	// remote edges of either sense capture timer b into both regs
	task automatic remote_test();
		logic [15:0] b0;
		int          r;
		sm_u.flip(0, 8);
		for (int k = 0; k < 6; k++) begin
			b0 = counts.timer_b_capture;
			r = 1 + $urandom % 4;
			sm_u.flip(0, TICK_B_CYC * r);
			check(16'(counts.timer_b_capture - b0), r);
			check(16'(counts.timer_b_capcompare - b0), r);
		end
		sm_u.flip(0, 8);
	endtask

	// each capture channel on two rises spaced in free-run steps
	task automatic capture_test();
		logic [21:0] c0;
		int          r, s;
		for (int i = 0; i < NUM_CAP; i++) begin
			sm_u.flip(7 - i, 8);
			c0 = counts.speed_phase_capture[i];
			r = 2 + $urandom % 5;
			s = 2 + $urandom % 5;
			sm_u.flip(7 - i, FREE_TICK_CYC * r);
			sm_u.flip(7 - i, FREE_TICK_CYC * s);
			check(22'(counts.speed_phase_capture[i] - c0), r + s);
			sm_u.flip(7 - i, 8);
		end
	endtask

	// high time over one carrier period against ceil(d*400/2^w)
	task automatic pwm_test(input logic edge_duty);
		int hi[6];
		int d, w;
		for (int j = 0; j < NUM_PWM; j++) begin
			duty.duty_hi[j] = 16'($urandom);
			duty.duty_lo[j] = 8'($urandom);
		end
		if (edge_duty) begin
			duty.duty_hi[0] = 16'hffff;
			duty.duty_lo[0] = 8'h00;
		end
		repeat (2 * PWM_CARRIER_CYC) @(negedge sys_clk);
		hi = '{default: 0};
		repeat (PWM_CARRIER_CYC) begin
			@(negedge sys_clk);
			for (int j = 0; j < 6; j++) hi[j] += pwm[j];
		end
		for (int j = 0; j < 6; j++) begin
			d = (j < 3) ? duty.duty_hi[j] : duty.duty_lo[j - 3];
			w = (j < 3) ? 65536 : 256;
			check(hi[j], (d * PWM_CARRIER_CYC + w - 1) / w);
		end
	endtask

	// main sequence
	initial begin
		void'($urandom(32'h5fbf_9c8c));
		rst_b = 1'b0;
		cfg = '1;
		cfg.general_timer_a_compare = CMP_A;
		cfg.general_timer_c_compare = CMP_C;
		cfg.vsync_mask_compare = 16'h0010;
		cfg.event_divider_compare = 8'h02;
		// frame compares fire once each in this run, duty one often
		cfg.frame_ref_compare = 16'h0020;
		cfg.frame_record_compare = 16'h0030;
		cfg.duty_compare_a = 16'h0001;
		duty = '0;
		prev_tape = 5'h00;
		{n_mismatch, compares, cyc, last_a, last_c, vs_cnt, ev_cnt} = '0;
		{fr_cnt, dm_cnt} = '0;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		// six capstan rises: divider pulses on every third
		repeat (12) sm_u.flip(4, 8);
		check(ev_cnt, 2);
		capture_test();
		tape_test(5'h01);
		tape_test(5'h00);
		tape_test(5'($urandom));
		remote_test();
		pwm_test(1'b1);
		pwm_test(1'b0);
		repeat (4) @(negedge sys_clk);
		check(exp_q.size(), 0);
		check(vs_cnt, 1);
		check(fr_cnt, 2);
		check(dm_cnt > 0, 1);
		check(last_a > 0 && last_c > 0, 1);
		final_report();
	end

	// hang guard, well beyond the expected run length
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		final_report();
	end
endmodule
